// ### ebtu_core.sv
/*
  external bus transfer unit: single, non-burst read and write bus cycles
  with wait states, bus monitor timeout and port-width splitting.
  assumes synchronous slave inputs and a requester that drops its request
  in the clock after req_ready takes it.
*/
`timescale 1ns/100ps
`include "ebtu_params.svh"
module ebtu_core
  import ebtu_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // requester side
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire ebtu_pkg::ebtu_addr_t req_addr,
  input  wire ebtu_pkg::ebtu_siz_t  req_size,
  input  wire logic                 req_write,
  input  wire logic                 req_code,
  input  wire logic                 req_super,
  input  wire logic [1:0]           req_class,
  input  wire ebtu_pkg::ebtu_port_t req_port,
  input  wire logic [31:0]          req_wdata,
  output logic                      done,
  output logic                      bus_error,
  output logic [31:0]               rd_data,
  // bus monitor
  input  wire logic                 mon_enable,
  input  wire ebtu_pkg::ebtu_tmr_t  mon_limit,
  // external bus
  output logic [`EBTU_ADDR_W-1:0]   addr,
  output logic [1:0]                access_class,
  output logic                      access_mode_bit,
  output logic                      rd_wr,
  output logic [1:0]                xfer_size_code,
  output logic                      transfer_start_n,
  input  wire logic                 transfer_ack_n,
  input  wire logic [31:0]          data_in,
  output logic [31:0]               data_out,
  output logic                      data_oe
);
  import ebtu_pkg::*;

  ebtu_state_e state_reg, state_next;
  ebtu_addr_t  addr_reg, addr_next;
  ebtu_siz_t   siz_reg, siz_next;
  ebtu_port_t  port_reg, port_next;
  logic        wr_reg, wr_next;
  logic        code_reg, code_next;
  logic        sup_reg, sup_next;
  logic [1:0]  cls_reg, cls_next;
  logic [31:0] op_reg, op_next;
  logic [31:0] rbuf_reg, rbuf_next;
  logic [31:0] rd_reg, rd_next;
  logic        done_reg, done_next;
  logic        err_reg, err_next;
  ebtu_tmr_t   tmr_reg, tmr_next;
  logic [31:0] lane_out;
  logic [31:0] lane_rd;
  logic [3:0]  lane_keep;
  logic [1:0]  step;
  logic        last_beat;
  logic        ack;
  logic        timeout;

  assign ack = ~transfer_ack_n;

  ebtu_lane_mux u_mux (
    .siz      (siz_reg),
    .ofs      (addr_reg[1:0]),
    .port     (port_reg),
    .wr_op    (op_reg),
    .bus_in   (data_in),
    .bus_out  (lane_out),
    .rd_merge (lane_rd),
    .rd_keep  (lane_keep)
  );

  // the next beat offset stays aligned to the port width, so an
  // illegal size/offset pair is never formed; the operand size code is kept
  // since burst-inhibited ports carry the beat size instead (see below)
  always_comb begin
    step      = 2'h1;
    last_beat = 1'b1;
    if (port_reg == `EBTU_PORT_16) begin
      step      = 2'h2;
      last_beat = (siz_reg == `EBTU_SIZ_BYTE) || (siz_reg == `EBTU_SIZ_WORD) ||
                  (addr_reg[1:0] == `EBTU_OFS_2);
    end else if (port_reg == `EBTU_PORT_8) begin
      unique case (siz_reg)
        `EBTU_SIZ_BYTE: last_beat = 1'b1;
        `EBTU_SIZ_WORD: last_beat = addr_reg[0];
        default:        last_beat = (addr_reg[1:0] == `EBTU_OFS_3);
      endcase
    end
  end

  // limit is a level input; a change also lands on a cycle already in flight
  assign timeout = mon_enable && (tmr_reg >= mon_limit);

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    siz_next   = siz_reg;
    port_next  = port_reg;
    wr_next    = wr_reg;
    code_next  = code_reg;
    sup_next   = sup_reg;
    cls_next   = cls_reg;
    op_next    = op_reg;
    rbuf_next  = rbuf_reg;
    rd_next    = rd_reg;
    done_next  = 1'b0;
    err_next   = 1'b0;
    tmr_next   = tmr_reg;
    unique case (state_reg)
      EBTU_IDLE: begin
        if (req_valid) begin
          state_next = EBTU_START;
          addr_next  = req_addr;
          siz_next   = req_size;
          port_next  = req_port;
          wr_next    = req_write;
          code_next  = req_code;
          sup_next   = req_super;
          cls_next   = req_class;
          op_next    = req_wdata;
          rbuf_next  = 32'h00000000;
          tmr_next   = `EBTU_ZERO_TMR;
        end
      end
      // start lasts this one clock only
      EBTU_START: begin
        state_next = EBTU_WAIT;
        tmr_next   = `EBTU_ONE_TMR;
      end
      EBTU_WAIT: begin
        tmr_next = tmr_reg + `EBTU_ONE_TMR;
        // sample acknowledge every edge; hold cycle while negated
        if (ack) begin
          for (int i = 0; i < 4; i++) begin
            if (lane_keep[i]) rbuf_next[8*i +: 8] = lane_rd[8*i +: 8];
          end
          if (last_beat) begin
            state_next = EBTU_IDLE;
            done_next  = 1'b1;
            rd_next    = rbuf_next;
          end else begin
            // next beat of a split transfer
            state_next = EBTU_START;
            addr_next  = {addr_reg[`EBTU_ADDR_W-1:2], addr_reg[1:0] + step};
          end
        end else if (timeout) begin
          // monitor expiry ends the cycle with an internal error
          state_next = EBTU_IDLE;
          done_next  = 1'b1;
          err_next   = 1'b1;
        end
      end
      default: state_next = EBTU_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= EBTU_IDLE;
      addr_reg  <= '0;
      siz_reg   <= `EBTU_SIZ_BYTE;
      port_reg  <= `EBTU_PORT_32;
      wr_reg    <= 1'b0;
      code_reg  <= 1'b0;
      sup_reg   <= 1'b0;
      cls_reg   <= 2'h0;
      op_reg    <= 32'h00000000;
      rbuf_reg  <= 32'h00000000;
      rd_reg    <= 32'h00000000;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
      tmr_reg   <= `EBTU_ZERO_TMR;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      siz_reg   <= siz_next;
      port_reg  <= port_next;
      wr_reg    <= wr_next;
      code_reg  <= code_next;
      sup_reg   <= sup_next;
      cls_reg   <= cls_next;
      op_reg    <= op_next;
      rbuf_reg  <= rbuf_next;
      rd_reg    <= rd_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
      tmr_reg   <= tmr_next;
    end
  end

  // bus outputs come straight from held registers
  assign addr             = addr_reg;
  assign access_class     = cls_reg;
  assign rd_wr            = ~wr_reg;
  assign transfer_start_n = ~(state_reg == EBTU_START);
  // code/data in first clock; privilege afterwards
  assign access_mode_bit  = (state_reg == EBTU_START) ? code_reg : sup_reg;
  // operand size code; inhibited narrow ports carry beat size
  always_comb begin
    xfer_size_code = siz_reg;
    if (port_reg == `EBTU_PORT_8)
      xfer_size_code = `EBTU_SIZ_BYTE;
    else if (port_reg == `EBTU_PORT_16 && siz_reg != `EBTU_SIZ_BYTE)
      xfer_size_code = `EBTU_SIZ_WORD;
  end
  // lanes stay zero on reads so nothing stale sits on a shared bus
  assign data_out  = wr_reg ? lane_out : 32'h00000000;
  assign data_oe   = wr_reg && (state_reg != EBTU_IDLE);
  assign req_ready = (state_reg == EBTU_IDLE);
  assign done      = done_reg;
  assign bus_error = err_reg;
  assign rd_data   = rd_reg;

  a_start_one_clk: assert property (@(posedge clk) disable iff (srst)
    !transfer_start_n |=> transfer_start_n)
    else $error("start held longer than one clock");
  a_start_no_wait: assert property (@(posedge clk) disable iff (srst)
    (state_reg == EBTU_WAIT && transfer_ack_n && !timeout) |=> transfer_start_n)
    else $error("start during wait state");
  a_addr_stable: assert property (@(posedge clk) disable iff (srst)
    (state_reg == EBTU_WAIT && transfer_ack_n) |=> $stable(addr) && $stable(xfer_size_code))
    else $error("address moved during wait");
  a_dir_read: assert property (@(posedge clk) disable iff (srst)
    (!transfer_start_n && !wr_reg) |-> rd_wr)
    else $error("read without direction high");
  a_dir_write: assert property (@(posedge clk) disable iff (srst)
    (!transfer_start_n && wr_reg) |-> !rd_wr && data_oe)
    else $error("write without direction low");
  a_mode_second: assert property (@(posedge clk) disable iff (srst)
    (!transfer_start_n) |=> (access_mode_bit == sup_reg))
    else $error("access mode not privilege in second clock");
  a_long_size: assert property (@(posedge clk) disable iff (srst)
    (!transfer_start_n && siz_reg == `EBTU_SIZ_LONG && port_reg == `EBTU_PORT_32) |->
      xfer_size_code == `EBTU_SIZ_LONG)
    else $error("longword size code not zero");
  a_ack_done: assert property (@(posedge clk) disable iff (srst)
    (state_reg == EBTU_WAIT && ack && last_beat) |=> done && !bus_error)
    else $error("acknowledge did not complete");
  a_timeout_err: assert property (@(posedge clk) disable iff (srst)
    (state_reg == EBTU_WAIT && !ack && timeout) |=> bus_error ##1 !bus_error)
    else $error("monitor expiry without bus error");
  a_split_16: assert property (@(posedge clk) disable iff (srst)
    (state_reg == EBTU_WAIT && ack && port_reg == `EBTU_PORT_16 &&
     siz_reg == `EBTU_SIZ_LONG && addr_reg[1:0] == `EBTU_OFS_0) |=>
      !transfer_start_n && addr[1:0] == `EBTU_OFS_2)
    else $error("longword to 16-bit port not split");
  a_start_taken: assert property (@(posedge clk) disable iff (srst)
    (req_valid && req_ready) |=> !transfer_start_n)
    else $error("request taken without start");
  a_word_size: assert property (@(posedge clk) disable iff (srst)
    (!transfer_start_n && siz_reg == `EBTU_SIZ_WORD && port_reg != `EBTU_PORT_8) |->
      xfer_size_code == `EBTU_SIZ_WORD)
    else $error("word size code not two");
  a_legal_beat: assert property (@(posedge clk) disable iff (srst)
    (!transfer_start_n && port_reg != `EBTU_PORT_8) |->
      !(xfer_size_code == `EBTU_SIZ_WORD && addr[0]) &&
      !(port_reg == `EBTU_PORT_32 && xfer_size_code inside {`EBTU_SIZ_LONG, `EBTU_SIZ_LINE} &&
        addr[1:0] != `EBTU_OFS_0))
    else $error("illegal size and offset on the bus");
  a_data_hold: assert property (@(posedge clk) disable iff (srst)
    (wr_reg && (state_reg == EBTU_START || (state_reg == EBTU_WAIT && transfer_ack_n && !timeout))) |=>
      data_oe && $stable(data_out))
    else $error("write data moved during wait");
  a_ctrl_hold: assert property (@(posedge clk) disable iff (srst)
    (state_reg == EBTU_WAIT && transfer_ack_n) |=> $stable(access_class) && $stable(rd_wr))
    else $error("controls moved during wait");
  a_read_quiet: assert property (@(posedge clk) disable iff (srst)
    (!transfer_start_n && !wr_reg) |-> !data_oe && data_out == 32'h00000000)
    else $error("read cycle drives data lanes");

  // own count of clocks since start, so the monitor timer is not judged by itself
  ebtu_tmr_t   chk_wait_reg, chk_wait_next;
  always_comb begin
    chk_wait_next = chk_wait_reg;
    if (!transfer_start_n)
      chk_wait_next = `EBTU_ONE_TMR;
    else if (state_reg == EBTU_WAIT)
      chk_wait_next = chk_wait_reg + `EBTU_ONE_TMR;
  end
  always_ff @(posedge clk) begin
    if (srst)
      chk_wait_reg <= `EBTU_ZERO_TMR;
    else
      chk_wait_reg <= chk_wait_next;
  end
  a_no_early_err: assert property (@(posedge clk) disable iff (srst)
    (state_reg == EBTU_WAIT && chk_wait_reg < mon_limit) |=> !bus_error)
    else $error("bus error before monitor time");
  c_split: cover property (@(posedge clk) disable iff (srst)
    !transfer_start_n && port_reg == `EBTU_PORT_16 && addr[1:0] == `EBTU_OFS_2);
  c_read: cover property (@(posedge clk) disable iff (srst) done && !wr_reg && !bus_error);
  c_write: cover property (@(posedge clk) disable iff (srst) done && wr_reg);
  c_waits: cover property (@(posedge clk) disable iff (srst)
    state_reg == EBTU_WAIT && transfer_ack_n ##1 state_reg == EBTU_WAIT && ack);
  c_error: cover property (@(posedge clk) disable iff (srst) bus_error);
endmodule

// ### ebtu_lane_mux.sv
/*
  write lane multiplexer and read lane extractor for one bus beat.
  assumes beats are already legal for the port; pure combinational.
*/
`timescale 1ns/100ps
`include "ebtu_params.svh"
module ebtu_lane_mux
  import ebtu_pkg::*;
(
  // beat description
  input  wire ebtu_pkg::ebtu_siz_t  siz,
  input  wire logic [1:0]           ofs,
  input  wire ebtu_pkg::ebtu_port_t port,
  // operand and bus lanes
  input  wire logic [31:0]          wr_op,
  input  wire logic [31:0]          bus_in,
  output logic [31:0]               bus_out,
  output logic [31:0]               rd_merge,
  output logic [3:0]                rd_keep
);
  logic [7:0] op0, op1, op2, op3;
  always_comb begin
    op0 = wr_op[31:24];
    op1 = wr_op[23:16];
    op2 = wr_op[15:8];
    op3 = wr_op[7:0];
    bus_out = 32'h00000000;
    // replicate so any port width finds its byte on its lanes
    unique case (siz)
      `EBTU_SIZ_BYTE: bus_out = {op3, op3, op3, op3};
      `EBTU_SIZ_WORD: begin
        if (ofs[0]) bus_out = {op3, 24'h000000};
        else        bus_out = {op2, op3, op2, op3};
      end
      default: begin
        unique case (ofs)
          `EBTU_OFS_0: bus_out = {op0, op1, op2, op3};
          `EBTU_OFS_1: bus_out = {op1, 24'h000000};
          `EBTU_OFS_2: bus_out = {op2, op3, op2, op3};
          default:     bus_out = {op3, 24'h000000};
        endcase
      end
    endcase
  end
  // pick only lanes that carry requested bytes; others stay masked
  always_comb begin
    rd_merge = 32'h00000000;
    rd_keep  = 4'h0;
    if (port == `EBTU_PORT_8) begin
      rd_merge[8*(3-ofs) +: 8] = bus_in[31:24];
      rd_keep[3-ofs] = 1'b1;
    end else if (port == `EBTU_PORT_16) begin
      rd_merge[8*(2-{ofs[1],1'b0}) +: 16] = bus_in[31:16];
      rd_keep[3-{ofs[1],1'b0}] = 1'b1;
      rd_keep[2-{ofs[1],1'b0}] = 1'b1;
      if (siz == `EBTU_SIZ_BYTE) rd_keep[2+ofs[0]-{ofs[1],1'b0}] = 1'b0;
    end else begin
      rd_merge = bus_in;
      unique case (siz)
        `EBTU_SIZ_BYTE: rd_keep[3-ofs] = 1'b1;
        `EBTU_SIZ_WORD: rd_keep = ofs[1] ? 4'h3 : 4'hC;
        default:        rd_keep = 4'hF;
      endcase
    end
  end
endmodule

// ### ebtu_params.svh
/*
  constants for the external bus transfer unit: size codes, offsets,
  port widths, address width and monitor timer width and values.
  assumes a single 100 MHz bus clock; included by the package, ebtu_core and ebtu_lane_mux.
*/
`ifndef EBTU_PARAMS_SVH
`define EBTU_PARAMS_SVH
`define EBTU_SIZ_LONG   2'h0
`define EBTU_SIZ_BYTE   2'h1
`define EBTU_SIZ_WORD   2'h2
`define EBTU_SIZ_LINE   2'h3
`define EBTU_PORT_32    2'h0
`define EBTU_PORT_16    2'h1
`define EBTU_PORT_8     2'h2
`define EBTU_OFS_0      2'h0
`define EBTU_OFS_1      2'h1
`define EBTU_OFS_2      2'h2
`define EBTU_OFS_3      2'h3
`define EBTU_ADDR_W     28
`define EBTU_TMR_W      16
`define EBTU_ONE_TMR    16'h0001
`define EBTU_ZERO_TMR   16'h0000
`endif

// ### ebtu_pkg.sv
/*
  types for the external bus transfer unit.
  assumes ebtu_params.svh is on the include path.
*/
`include "ebtu_params.svh"
package ebtu_pkg;
  typedef logic [1:0]                 ebtu_siz_t;
  typedef logic [1:0]                 ebtu_port_t;
  typedef logic [`EBTU_ADDR_W-1:0]    ebtu_addr_t;
  typedef logic [`EBTU_TMR_W-1:0]     ebtu_tmr_t;
  typedef enum logic [1:0] {
    EBTU_IDLE  = 2'b00,
    EBTU_START = 2'b01,
    EBTU_WAIT  = 2'b10
  } ebtu_state_e;
endpackage

// ### ebtu_slave_model.sv
/*
  behavioural slave on the far side of the external bus: a 16-byte memory
  on an 8-, 16- or 32-bit port with a programmable number of wait states.
  assumes the unit holds address and size stable until acknowledge.
*/
`timescale 1ns/100ps
module ebtu_slave_model
  import ebtu_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // bus from the unit
  input  wire logic [27:0] addr,
  input  wire logic        rd_wr,
  input  wire logic [1:0]  xfer_size_code,
  input  wire logic        transfer_start_n,
  input  wire logic [31:0] data_out,
  // model setup: port width code, waits (8'hFF never answers)
  input  wire logic [1:0]  port,
  input  wire logic [7:0]  waits,
  // answer
  output logic             transfer_ack_n,
  output logic [31:0]      data_in
);
  logic [7:0] mem [16];
  logic [7:0] cnt;
  logic       busy;
  logic [7:0] junk;

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'(8'h5A ^ (i * 8'h13));
  end

  // port sits on the top lanes; byte address of lane l counts down the bus
  function automatic logic lane_ok(input int l, output int b);
    int pb;
    int n;
    int a;
    pb = (port == 2'h0) ? 4 : ((port == 2'h1) ? 2 : 1);
    n  = (xfer_size_code == 2'h1) ? 1 : ((xfer_size_code == 2'h2) ? 2 : 4);
    a  = int'(addr[3:0]);
    b  = (a & ~(pb - 1)) + l;
    return (l < pb) && (b >= a) && (b < a + n);
  endfunction

  // unrequested lanes carry a changing pattern so stale data never helps
  always_comb begin
    int b;
    b = 0;
    for (int l = 0; l < 4; l++) begin
      data_in[31-8*l -: 8] = (!transfer_ack_n && lane_ok(l, b)) ? mem[b] : ~junk;
    end
  end

  always @(posedge clk) begin
    int b;
    junk <= junk + 8'h3B;
    if (srst) begin
      transfer_ack_n <= 1'b1;
      busy           <= 1'b0;
      junk           <= 8'h00;
    end else if (!transfer_ack_n) begin
      transfer_ack_n <= 1'b1;
      if (!rd_wr) begin
        for (int l = 0; l < 4; l++) if (lane_ok(l, b)) mem[b] <= data_out[31-8*l -: 8];
      end
    end else if (!transfer_start_n) begin
      cnt            <= waits;
      busy           <= (waits != 8'h00);
      transfer_ack_n <= (waits != 8'h00);
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01 && waits != 8'hFF) begin
        transfer_ack_n <= 1'b0;
        busy           <= 1'b0;
      end
    end
  end
endmodule

// ### test_external_bus_transfer_unit.sv
/*
  self-checking bench for the external bus transfer unit: reads and writes of
  every legal size and offset on all three port widths, wait states, timeout.
  assumes ebtu_core and ebtu_slave_model; inputs change on falling edges.
*/
`timescale 1ns/100ps
module test_external_bus_transfer_unit;
  import ebtu_pkg::*;
  logic        clk, srst, req_valid, req_ready, req_write, req_code, req_super, done, bus_error;
  logic        mon_enable, access_mode_bit, rd_wr, transfer_start_n, transfer_ack_n, data_oe;
  logic [1:0]  req_size, req_port, req_class, access_class, xfer_size_code, s_port;
  logic [27:0] req_addr, addr;
  logic [31:0] req_wdata, rd_data, data_in, data_out;
  logic [15:0] mon_limit;
  logic [7:0]  s_waits;
  logic [7:0]  shadow [16];
  int          mismatches, n_compared;

  ebtu_core dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_size(req_size), .req_write(req_write), .req_code(req_code), .req_super(req_super),
    .req_class(req_class), .req_port(req_port), .req_wdata(req_wdata), .done(done), .bus_error(bus_error),
    .rd_data(rd_data), .mon_enable(mon_enable), .mon_limit(mon_limit), .addr(addr),
    .access_class(access_class), .access_mode_bit(access_mode_bit), .rd_wr(rd_wr),
    .xfer_size_code(xfer_size_code), .transfer_start_n(transfer_start_n), .transfer_ack_n(transfer_ack_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  ebtu_slave_model u_slave (.clk(clk), .srst(srst), .addr(addr), .rd_wr(rd_wr), .xfer_size_code(xfer_size_code),
    .transfer_start_n(transfer_start_n), .data_out(data_out), .port(s_port), .waits(s_waits),
    .transfer_ack_n(transfer_ack_n), .data_in(data_in));

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one whole transfer, called and left at a falling edge so calls chain back to back
  task xfer(input logic [27:0] a, input logic [1:0] sz, input logic wr, input logic [1:0] pt,
            input logic [31:0] wd, input logic [7:0] ws, input logic [1:0] cls, output logic err);
    int n, pb, bb, k, t;
    logic [27:0] ba;
    logic fresh, skip;
    n = (sz == 2'h1) ? 1 : ((sz == 2'h2) ? 2 : 4);
    pb = (pt == 2'h0) ? 4 : ((pt == 2'h1) ? 2 : 1);
    bb = (n < pb) ? n : pb;
    {req_addr, req_size, req_write, req_port, req_wdata, req_class} = {a, sz, wr, pt, wd, cls};
    {req_code, req_super, s_port, s_waits, req_valid} = {cls[0], cls[1], pt, ws, 1'b1};
    check("ready", req_ready, 1);
    @(negedge clk);
    req_valid = 1'b0;
    check("start in first clock", transfer_start_n, 0);
    {k, t, ba, fresh, skip} = {32'd0, 32'd0, a, 1'b0, 1'b0};
    while (done !== 1'b1 && t < 400) begin
      if (transfer_start_n === 1'b0) begin
        ba = a + 28'(k * bb);
        check("beat address", addr, ba);
        check("direction", rd_wr, !wr);
        check("access class", access_class, cls);
        check("mode first clock", access_mode_bit, cls[0]);
        check("lane enable", data_oe, wr);
        if (!(sz == 2'h3 && bb == 4)) check("size code", xfer_size_code, (bb == 1) ? 1 : ((bb == 2) ? 2 : 0));
        if (wr) check("top lane", data_out[31:24], wd[31-8*(k*bb+4-n) -: 8]);
        k++;
        fresh = 1'b1;
      end else if (!skip) begin
        check("address held", addr, ba);
        check("direction held", rd_wr, !wr);
        if (fresh) check("mode second clock", access_mode_bit, cls[1]);
        fresh = 1'b0;
      end
      skip = (transfer_ack_n === 1'b0);
      @(negedge clk);
      t++;
    end
    check("done seen", done, 1);
    err = bus_error;
    if (!err) check("beat count", k, n / bb);
  endtask

  task read_check(input logic [27:0] a, input logic [1:0] sz, input logic [1:0] pt, input logic [7:0] ws);
    logic [31:0] exp, mask;
    logic err;
    int n;
    n = (sz == 2'h1) ? 1 : ((sz == 2'h2) ? 2 : 4);
    {exp, mask} = 64'h0;
    // read bytes come back on the lanes of their offset inside the longword
    for (int k = 0; k < n; k++) begin
      exp[8*(3-int'(a[1:0])-k) +: 8] = shadow[(a[3:0] + k) % 16];
      mask[8*(3-int'(a[1:0])-k) +: 8] = 8'hFF;
    end
    xfer(a, sz, 1'b0, pt, 32'h0, ws, a[3:2], err);
    check("read data", rd_data & mask, exp);
    check("no error", err, 0);
  endtask

  task t_reset;
    check("reset start", transfer_start_n, 1);
    check("reset done", {done, bus_error, data_oe}, 0);
    check("reset direction", rd_wr, 1);
    check("reset addr", addr, 0);
    check("reset read data", rd_data, 0);
  endtask

  // every legal size/offset on every port: reads when wr is low, writes with read-back when wr is high
  task t_all_access(input logic wr);
    static logic [1:0] szs [8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
    static logic [1:0] ofs [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [27:0] a;
    logic [31:0] wd;
    logic err;
    int n;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 8; c++) begin
        a = 28'h0ABC120 + 28'(4 * (c % 4)) + 28'(ofs[c]);
        if (!wr) read_check(a, szs[c], 2'(p), 8'((c + p) % 3));
        else begin
          wd = 32'h8C4F2B00 + 32'(c * 16 + p);
          n = (szs[c] == 2'h1) ? 1 : ((szs[c] == 2'h2) ? 2 : 4);
          xfer(a, szs[c], 1'b1, 2'(p), wd, 8'((c + p + 1) % 3), 2'(c), err);
          for (int k = 0; k < n; k++) shadow[(a[3:0] + k) % 16] = wd[31-8*(4-n+k) -: 8];
          check("write no error", err, 0);
          read_check(a, szs[c], 2'(2 - p), 8'h00);
        end
      end
    end
  endtask

  task t_timeout;
    logic err;
    read_check(28'h0000004, 2'h0, 2'h0, 8'h07);
    mon_limit = 16'h0004;
    xfer(28'h0000008, 2'h0, 1'b0, 2'h0, 32'h0, 8'hFF, 2'h2, err);
    check("bus error on silence", err, 1);
    mon_enable = 1'b0;
    read_check(28'h0000000, 2'h0, 2'h0, 8'h07);
    mon_enable = 1'b1;
    mon_limit = 16'h0020;
    read_check(28'h000000C, 2'h0, 2'h1, 8'h01);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done;
  end

  initial begin
    {mismatches, n_compared} = 64'd0;
    {srst, req_valid, req_write, req_code, req_super, mon_enable} = 6'b100000;
    {req_size, req_port, req_class, s_port} = 8'h00;
    {req_addr, req_wdata, s_waits, mon_limit} = {28'h0, 32'h0, 8'h00, 16'h0020};
    for (int i = 0; i < 16; i++) shadow[i] = 8'(8'h5A ^ (i * 8'h13));
    repeat (12) @(negedge clk);
    srst = 1'b0;
    mon_enable = 1'b1;
    @(negedge clk);
    t_reset;
    t_all_access(1'b0);
    t_all_access(1'b1);
    t_timeout;
    test_done;
  end
endmodule
